/* File: core/chb_edge_sync.sv */
`timescale 1ns/1ps
module chb_edge_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);

  etm_ccrb_pkg::edge_state_t r;
  etm_ccrb_pkg::edge_state_t next_r;

  // sync_a is read only by sync_b; edges are taken from sync_b onward
  always_comb begin
    next_r = r;
    next_r.sync_a = pin_in;
    next_r.sync_b = r.sync_a;
    next_r.last = r.sync_b;
    next_r.rise = r.sync_b & ~r.last;
    next_r.fall = ~r.sync_b & r.last;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= etm_ccrb_pkg::edge_reset;
    end else begin
      r <= next_r;
    end
  end

  assign rise = r.rise;
  assign fall = r.fall;

endmodule // chb_edge_sync

/* File: core/etm_ccrb_output_function_control.sv */
// Notes on behaviour
// - pwm mode selector: 00 inactive, 01 active, 10 pwm wave, 11 single pulse.
// - compare mode: level bit gives pin level before any match, 0 low, 1 high.
// - pwm mode: level bit picks active level, 0 active low, 1 active high.
// - timer/counter mode: selector has no effect on pins; level bit acts only on run enable rising edge.
// - compare mode: match drives pin high, low or toggles, per selector.
// - compare mode, selector 00: a match leaves the pin unchanged.
// - pin loads initial level from level bit on run enable rising edge.
// - invert bit inverts output pins when set; no effect in timer/counter mode.
`timescale 1ns/1ps
module etm_ccrb_output_function_control (
  input wire logic ref_clk,
  input wire logic reset_n,
  input etm_ccrb_pkg::apb_req_t apb_req,
  output etm_ccrb_pkg::apb_rsp_t apb_rsp,
  input wire logic compare_match_b,
  input wire logic pwm_wave,
  input wire logic pulse_wave,
  input wire logic chb_capture_pin,
  output logic chb_out_pin_a,
  output logic chb_out_pin_b,
  output logic chb_out_pin_c,
  output logic chb_pin_oe,
  output logic capture_event,
  output logic timer_run_enable,
  output logic [1:0] ccrb_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state and capture pin edges

  etm_ccrb_pkg::etm_state_t r;
  etm_ccrb_pkg::etm_state_t next_r;

  logic cap_rise;
  logic cap_fall;
  logic access;
  logic done;
  logic wr;
  logic run_rise;
  logic cap_hit;
  logic active_lvl;

  chb_edge_sync u_edge (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(chb_capture_pin),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus qualifiers

  always_comb begin
    access = apb_req.psel & apb_req.penable;
    done = access & r.rsp.pready;
    wr = done & apb_req.pwrite;
    run_rise = wr & (apb_req.paddr == etm_ccrb_pkg::run_offset)
      & apb_req.pwdata[etm_ccrb_pkg::run_pos] & ~r.run;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.rsp.pready = 1'b0;
    next_r.cap_pulse = 1'b0;
    active_lvl = r.ctrl.chb_output_level_ctrl;
    cap_hit = 1'b0;

    // apb slave: pready rises one cycle into the access phase
    if (access & ~r.rsp.pready) begin
      next_r.rsp.pready = 1'b1;
      next_r.rsp.pslverr = 1'b0;
      case (apb_req.paddr)
        etm_ccrb_pkg::ctrl_offset: begin
          next_r.rsp.prdata = {24'h000000, r.ctrl};
        end
        etm_ccrb_pkg::run_offset: begin
          next_r.rsp.prdata = {31'h00000000, r.run};
        end
        etm_ccrb_pkg::status_offset: begin
          next_r.rsp.prdata = {29'h00000000, r.cap_seen, r.out_pin, r.pin_level};
        end
        default: begin
          next_r.rsp.prdata = 32'h00000000;
          next_r.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // register writes take effect on the completing edge only
    if (wr) begin
      case (apb_req.paddr)
        etm_ccrb_pkg::ctrl_offset: begin
          // alignment bit 1 is read only
          next_r.ctrl = {apb_req.pwdata[7:2], r.ctrl.pwm_align_hi, apb_req.pwdata[0]};
        end
        etm_ccrb_pkg::run_offset: begin
          next_r.run = apb_req.pwdata[etm_ccrb_pkg::run_pos];
        end
        etm_ccrb_pkg::status_offset: begin
          if (apb_req.pwdata[etm_ccrb_pkg::stat_cap_pos]) begin
            next_r.cap_seen = 1'b0;
          end
        end
        default: begin
          next_r.cap_seen = next_r.cap_seen;
        end
      endcase
    end

    // output level per mode
    case (r.ctrl.mode)
      etm_ccrb_pkg::mode_compare: begin
        if (r.run & compare_match_b) begin
          case (r.ctrl.chb_outfunc_sel)
            etm_ccrb_pkg::cmp_sel_low: next_r.pin_level = 1'b0;
            etm_ccrb_pkg::cmp_sel_high: next_r.pin_level = 1'b1;
            etm_ccrb_pkg::cmp_sel_toggle: next_r.pin_level = ~r.pin_level;
            default: next_r.pin_level = r.pin_level;
          endcase
        end
      end
      etm_ccrb_pkg::mode_pwm: begin
        case (r.ctrl.chb_outfunc_sel)
          etm_ccrb_pkg::pwm_sel_inactive: next_r.pin_level = ~active_lvl;
          etm_ccrb_pkg::pwm_sel_active: next_r.pin_level = active_lvl;
          etm_ccrb_pkg::pwm_sel_wave: next_r.pin_level = pwm_wave ? active_lvl : ~active_lvl;
          default: next_r.pin_level = pulse_wave ? active_lvl : ~active_lvl;
        endcase
      end
      etm_ccrb_pkg::mode_capture: begin
        if (r.run) begin
          case (r.ctrl.chb_outfunc_sel)
            etm_ccrb_pkg::cap_sel_rise: cap_hit = cap_rise;
            etm_ccrb_pkg::cap_sel_fall: cap_hit = cap_fall;
            etm_ccrb_pkg::cap_sel_both: cap_hit = cap_rise | cap_fall;
            default: cap_hit = 1'b0;
          endcase
        end
      end
      default: begin
        // timer/counter: pin holds, selector unused; level bit only loads the pin on run enable rising edge
        next_r.pin_level = r.pin_level;
      end
    endcase

    // initial level on run enable rising edge
    if (run_rise) begin
      next_r.pin_level = r.ctrl.chb_output_level_ctrl;
    end

    // capture event; set wins over a same-cycle clear
    next_r.cap_pulse = cap_hit;
    if (cap_hit) begin
      next_r.cap_seen = 1'b1;
    end

    next_r.out_pin = next_r.pin_level
      ^ (r.ctrl.chb_output_invert & (r.ctrl.mode != etm_ccrb_pkg::mode_timer));
    next_r.pin_oe = (r.ctrl.mode != etm_ccrb_pkg::mode_capture);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= etm_ccrb_pkg::state_reset;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign apb_rsp = r.rsp;
  assign chb_out_pin_a = r.out_pin;
  assign chb_out_pin_b = r.out_pin;
  assign chb_out_pin_c = r.out_pin;
  assign chb_pin_oe = r.pin_oe;
  assign capture_event = r.cap_pulse;
  assign timer_run_enable = r.run;
  assign ccrb_mode = r.ctrl.mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!reset_n);

  sequence pwm_sel_seen(logic [1:0] code);
    (r.ctrl.mode == etm_ccrb_pkg::mode_pwm) && (r.ctrl.chb_outfunc_sel == code) && !run_rise;
  endsequence

  sequence cmp_match_seen(logic [1:0] code);
    (r.ctrl.mode == etm_ccrb_pkg::mode_compare) && (r.ctrl.chb_outfunc_sel == code)
      && r.run && compare_match_b && !run_rise;
  endsequence

  sequence apb_setup_then_access;
    (apb_req.psel && !apb_req.penable) ##1 (apb_req.psel && apb_req.penable);
  endsequence

  chk_pwm_force_inactive: assert property (
    pwm_sel_seen(etm_ccrb_pkg::pwm_sel_inactive)
      |=> r.pin_level == !$past(r.ctrl.chb_output_level_ctrl))
    else $error("pwm force inactive gave wrong level");

  chk_pwm_wave_level: assert property (
    pwm_sel_seen(etm_ccrb_pkg::pwm_sel_wave)
      |=> r.pin_level == ($past(pwm_wave) == $past(r.ctrl.chb_output_level_ctrl)))
    else $error("pwm wave level or polarity wrong");

  chk_pulse_active_level: assert property (
    pwm_sel_seen(etm_ccrb_pkg::pwm_sel_pulse)
      |=> r.pin_level == ($past(pulse_wave) == $past(r.ctrl.chb_output_level_ctrl)))
    else $error("single pulse level wrong");

  chk_run_init_level: assert property (
    run_rise |=> r.run && (r.pin_level == $past(r.ctrl.chb_output_level_ctrl)))
    else $error("initial level not loaded on run enable");

  chk_cmp_toggle_pin: assert property (
    cmp_match_seen(etm_ccrb_pkg::cmp_sel_toggle) |=> r.pin_level != $past(r.pin_level))
    else $error("compare toggle did not toggle");

  chk_cmp_high_pin: assert property (
    cmp_match_seen(etm_ccrb_pkg::cmp_sel_high) |=> r.pin_level ##1 1'b1)
    else $error("compare high did not drive high");

  chk_cmp_hold_pin: assert property (
    cmp_match_seen(etm_ccrb_pkg::cmp_sel_hold) |=> $stable(r.pin_level))
    else $error("compare hold changed the pin");

  chk_timer_mode_idle: assert property (
    ((r.ctrl.mode == etm_ccrb_pkg::mode_timer) && !run_rise) |=> $stable(r.pin_level))
    else $error("pin moved in timer/counter mode");

  chk_invert_output: assert property (
    r.out_pin == (r.pin_level ^ $past(r.ctrl.chb_output_invert
      && (r.ctrl.mode != etm_ccrb_pkg::mode_timer))))
    else $error("output polarity wrong");

  chk_capture_select: assert property (
    r.cap_pulse |-> $past(r.ctrl.mode == etm_ccrb_pkg::mode_capture)
      && $past(r.ctrl.chb_outfunc_sel != etm_ccrb_pkg::cap_sel_off) && r.cap_seen)
    else $error("capture event with capture disabled");

  chk_apb_ready_time: assert property (
    apb_setup_then_access |=> r.rsp.pready ##1 !r.rsp.pready)
    else $error("apb answer not in one cycle");

  chk_pwm_force_active: assert property (
    pwm_sel_seen(etm_ccrb_pkg::pwm_sel_active)
      |=> r.pin_level == $past(r.ctrl.chb_output_level_ctrl))
    else $error("pwm force active gave wrong level");

  chk_cmp_low_pin: assert property (
    cmp_match_seen(etm_ccrb_pkg::cmp_sel_low) |=> !r.pin_level)
    else $error("compare low did not drive low");

  chk_cmp_run_gate: assert property (
    ((r.ctrl.mode == etm_ccrb_pkg::mode_compare) && !r.run && !run_rise)
      |=> $stable(r.pin_level))
    else $error("pin moved in compare mode while stopped");

  chk_capture_needs_run: assert property (
    r.cap_pulse |-> $past(r.run))
    else $error("capture event while stopped");

  chk_capture_rise_edge: assert property (
    (r.cap_pulse && $past(r.ctrl.chb_outfunc_sel == etm_ccrb_pkg::cap_sel_rise))
      |-> $past(cap_rise))
    else $error("rising capture without a rising edge");

  chk_capture_fall_edge: assert property (
    (r.cap_pulse && $past(r.ctrl.chb_outfunc_sel == etm_ccrb_pkg::cap_sel_fall))
      |-> $past(cap_fall))
    else $error("falling capture without a falling edge");

  chk_capture_sticky: assert property (
    cap_hit |=> r.cap_seen)
    else $error("capture seen flag not set");

  chk_apb_unmapped: assert property (
    (apb_req.psel && apb_req.penable && !r.rsp.pready
      && (apb_req.paddr > etm_ccrb_pkg::status_offset)) |=> r.rsp.pready && r.rsp.pslverr)
    else $error("unmapped access without error");

  chk_ctrl_ro_bit: assert property (
    $stable(r.ctrl.pwm_align_hi))
    else $error("read only alignment bit changed");

endmodule // etm_ccrb_output_function_control

/* File: core/etm_ccrb_pkg.sv */
package etm_ccrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses, one aligned 32-bit word each)
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] run_offset = 8'h04;
  localparam logic [7:0] status_offset = 8'h08;

  // status word bit positions
  localparam int stat_level_pos = 0;
  localparam int stat_pin_pos = 1;
  localparam int stat_cap_pos = 2;

  // run register bit position
  localparam int run_pos = 0;

  ////////////////////////////////////////////////////////////////////////////
  // operating mode codes of the channel
  localparam logic [1:0] mode_compare = 2'h0;
  localparam logic [1:0] mode_capture = 2'h1;
  localparam logic [1:0] mode_pwm = 2'h2;
  localparam logic [1:0] mode_timer = 2'h3;

  // output function selector, compare match output mode
  localparam logic [1:0] cmp_sel_hold = 2'h0;
  localparam logic [1:0] cmp_sel_low = 2'h1;
  localparam logic [1:0] cmp_sel_high = 2'h2;
  localparam logic [1:0] cmp_sel_toggle = 2'h3;

  // output function selector, pwm / single pulse mode
  localparam logic [1:0] pwm_sel_inactive = 2'h0;
  localparam logic [1:0] pwm_sel_active = 2'h1;
  localparam logic [1:0] pwm_sel_wave = 2'h2;
  localparam logic [1:0] pwm_sel_pulse = 2'h3;

  // output function selector, capture input mode
  localparam logic [1:0] cap_sel_rise = 2'h0;
  localparam logic [1:0] cap_sel_fall = 2'h1;
  localparam logic [1:0] cap_sel_both = 2'h2;
  localparam logic [1:0] cap_sel_off = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // control register layout, msb first
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] chb_outfunc_sel;
    logic chb_output_level_ctrl;
    logic chb_output_invert;
    logic pwm_align_hi;
    logic pwm_align_lo;
  } ctrl_t;

  localparam logic [7:0] ctrl_reset = 8'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic run;
    logic pin_level;
    logic out_pin;
    logic pin_oe;
    logic cap_pulse;
    logic cap_seen;
    apb_rsp_t rsp;
  } etm_state_t;

  localparam etm_state_t state_reset = '0;

  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic last;
    logic rise;
    logic fall;
  } edge_state_t;

  localparam edge_state_t edge_reset = '0;

endpackage

/* File: tb/etm_ccrb_output_function_control_test.sv */
`timescale 1ns/1ps
module etm_ccrb_output_function_control_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  etm_ccrb_pkg::apb_req_t apb_req = '0;
  etm_ccrb_pkg::apb_rsp_t apb_rsp;
  logic compare_match_b = 1'b0;
  logic pwm_wave = 1'b0;
  logic pulse_wave = 1'b0;
  logic chb_capture_pin = 1'b0;
  logic chb_out_pin_a;
  logic chb_out_pin_b;
  logic chb_out_pin_c;
  logic chb_pin_oe;
  logic capture_event;
  logic timer_run_enable;
  logic [1:0] ccrb_mode;
  logic [31:0] rd;
  logic rd_err;
  int errors = 0;
  int checks = 0;

  always #20 ref_clk = ~ref_clk;

  etm_ccrb_output_function_control dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .compare_match_b(compare_match_b),
    .pwm_wave(pwm_wave),
    .pulse_wave(pulse_wave),
    .chb_capture_pin(chb_capture_pin),
    .chb_out_pin_a(chb_out_pin_a),
    .chb_out_pin_b(chb_out_pin_b),
    .chb_out_pin_c(chb_out_pin_c),
    .chb_pin_oe(chb_pin_oe),
    .capture_event(capture_event),
    .timer_run_enable(timer_run_enable),
    .ccrb_mode(ccrb_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // all three pins must agree; one edge lets the registered level settle
  task automatic chk_pins(input logic exp, input string what);
    @(posedge ref_clk);
    @(negedge ref_clk);
    checks++;
    if ({chb_out_pin_a, chb_out_pin_b, chb_out_pin_c} !== {3{exp}}) begin
      errors++;
      $display("FAIL %0t %s pins %b exp %b", $time, what,
               {chb_out_pin_a, chb_out_pin_b, chb_out_pin_c}, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    rd_err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  function automatic logic [31:0] cv(logic [1:0] m, logic [1:0] s, logic l, logic i);
    return {24'h0, m, s, l, i, 2'b00};
  endfunction

  task automatic match;
    @(posedge ref_clk);
    compare_match_b <= 1'b1;
    @(posedge ref_clk);
    compare_match_b <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    apb(etm_ccrb_pkg::ctrl_offset, 1'b0, 32'h0);
    chk_word(rd, {24'h0, etm_ccrb_pkg::ctrl_reset}, "ctrl reset");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, 32'hff);
    apb(etm_ccrb_pkg::ctrl_offset, 1'b0, 32'h0);
    chk_word(rd, 32'hfd, "ctrl rw");
    chk_word({30'h0, ccrb_mode}, {30'h0, etm_ccrb_pkg::mode_timer}, "mode out");
    apb(etm_ccrb_pkg::run_offset, 1'b0, 32'h0);
    chk_word({rd[30:0], timer_run_enable}, 32'h0, "run off");
    apb(8'h40, 1'b0, 32'h0);
    chk_word({rd[30:0], rd_err}, 32'h1, "unmapped");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, 32'h0);
    $display("test_regs done");
  endtask

  task automatic test_compare;
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_compare, 2'h0, 1'b1, 1'b0));
    apb(etm_ccrb_pkg::run_offset, 1'b1, 32'h1);
    chk_pins(1'b1, "initial high");
    chk_word({30'h0, timer_run_enable, chb_pin_oe}, 32'h3, "run and oe");
    match();
    chk_pins(1'b1, "hold on match");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_compare, 2'h1, 1'b1, 1'b0));
    match();
    chk_pins(1'b0, "match low");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_compare, 2'h3, 1'b1, 1'b0));
    match();
    chk_pins(1'b1, "toggle up");
    match();
    chk_pins(1'b0, "toggle down");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_compare, 2'h2, 1'b1, 1'b0));
    match();
    chk_pins(1'b1, "match high");
    apb(etm_ccrb_pkg::run_offset, 1'b1, 32'h0);
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_compare, 2'h1, 1'b0, 1'b0));
    match();
    chk_pins(1'b1, "stopped ignores match");
    apb(etm_ccrb_pkg::run_offset, 1'b1, 32'h1);
    chk_pins(1'b0, "initial low");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_compare, 2'h2, 1'b0, 1'b1));
    chk_pins(1'b1, "inverted");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_timer, 2'h3, 1'b1, 1'b1));
    match();
    chk_pins(1'b0, "timer mode");
    $display("test_compare done");
  endtask

  task automatic test_pwm;
    logic exp;
    for (int l = 0; l < 2; l++) begin
      for (int s = 0; s < 4; s++) begin
        for (int w = 0; w < 2; w++) begin
          @(posedge ref_clk);
          pwm_wave <= w[0];
          pulse_wave <= ~w[0];
          apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_pwm, s[1:0], l[0], 1'b0));
          case (s)
            0: exp = ~l[0];
            1: exp = l[0];
            2: exp = w[0] ? l[0] : ~l[0];
            default: exp = ~w[0] ? l[0] : ~l[0];
          endcase
          chk_pins(exp, "pwm output");
        end
      end
    end
    $display("test_pwm done");
  endtask

  task automatic test_capture;
    int n;
    for (int s = 0; s < 4; s++) begin
      apb(etm_ccrb_pkg::ctrl_offset, 1'b1, cv(etm_ccrb_pkg::mode_capture, s[1:0], 1'b0, 1'b0));
      for (int e = 0; e < 2; e++) begin
        n = 0;
        @(posedge ref_clk);
        chb_capture_pin <= ~e[0];
        repeat (8) begin
          @(negedge ref_clk);
          if (capture_event === 1'b1) n++;
        end
        chk_word(n, (e == 0) ? (s == 0 || s == 2) : (s == 1 || s == 2), "capture");
      end
      chk_word({31'h0, chb_pin_oe}, 32'h0, "oe in capture");
    end
    apb(etm_ccrb_pkg::status_offset, 1'b0, 32'h0);
    chk_word(rd, 32'h1 << etm_ccrb_pkg::stat_cap_pos, "capture seen");
    apb(etm_ccrb_pkg::status_offset, 1'b1, 32'h1 << etm_ccrb_pkg::stat_cap_pos);
    apb(etm_ccrb_pkg::status_offset, 1'b0, 32'h0);
    chk_word(rd, 32'h0, "capture cleared");
    $display("test_capture done");
  endtask

  task automatic test_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk_word({27'h0, ccrb_mode, timer_run_enable, capture_event, chb_pin_oe}, 32'h0, "in reset");
    chk_pins(1'b0, "pins after reset");
    chk_word({31'h0, chb_pin_oe}, 32'h1, "oe after reset");
    apb(etm_ccrb_pkg::ctrl_offset, 1'b0, 32'h0);
    chk_word(rd, {24'h0, etm_ccrb_pkg::ctrl_reset}, "ctrl after reset");
    $display("test_reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    test_regs();
    test_compare();
    test_pwm();
    test_capture();
    test_reset();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
endmodule // etm_ccrb_output_function_control_test
